// ---- src/cwgf_pkg.sv ----
package cwgf_pkg;

  // ****************************************
  // clock and oscillator timing
  // ****************************************
  localparam int unsigned CWGF_CLK_NS = 40;
  localparam int unsigned CWGF_OSC_NOM_KHZ = 8000;
  localparam int unsigned CWGF_TICK_DIV = 3;
  localparam int unsigned CWGF_TICK_NS = CWGF_CLK_NS * CWGF_TICK_DIV;
  localparam int unsigned CWGF_OSC_START_MIN_NS = 280;
  localparam int unsigned CWGF_OSC_START_MAX_NS = 700;
  localparam int unsigned CWGF_OSC_START_CYC =
    (CWGF_OSC_START_MAX_NS + CWGF_CLK_NS - 1) / CWGF_CLK_NS;
  localparam int unsigned CWGF_OSC_START_MIN_CYC =
    (CWGF_OSC_START_MIN_NS + CWGF_CLK_NS - 1) / CWGF_CLK_NS;

  // ****************************************
  // pulse qualification band
  // ****************************************
  localparam int unsigned CWGF_GLITCH_MAX_NS = 1500;
  localparam int unsigned CWGF_WAKE_MIN_NS = 5000;
  localparam int unsigned CWGF_GLITCH_CYC =
    (CWGF_GLITCH_MAX_NS + CWGF_CLK_NS - 1) / CWGF_CLK_NS;
  localparam int unsigned CWGF_THRESH_NS = 3720;
  localparam int unsigned CWGF_THRESH_TICKS = CWGF_THRESH_NS / CWGF_TICK_NS;
  localparam int unsigned CWGF_ERR_NEG_PCT = 3;
  localparam int unsigned CWGF_ERR_POS_PCT = 5;
  localparam bit CWGF_BAND_OK =
    (CWGF_THRESH_NS * 100 / (100 - CWGF_ERR_NEG_PCT) <= CWGF_WAKE_MIN_NS) &&
    (CWGF_THRESH_NS * 100 / (100 + CWGF_ERR_POS_PCT) >= CWGF_GLITCH_MAX_NS);

  // ****************************************
  // worst case latency, in picoseconds
  // ****************************************
  localparam int unsigned CWGF_LAT_PD_PS = 4834380;
  localparam int unsigned CWGF_LAT_RUN_PS = 4414380;
  localparam int unsigned CWGF_LAT_PD_CYC = CWGF_LAT_PD_PS / (CWGF_CLK_NS * 1000);
  localparam int unsigned CWGF_LAT_RUN_CYC = CWGF_LAT_RUN_PS / (CWGF_CLK_NS * 1000);

  // ****************************************
  // types
  // ****************************************
  typedef struct packed {
    logic ctrl_stop;
    logic very_low_power_states;
    logic osc_standby;
    logic osc_powerdown;
  } cwgf_mode_t;

  typedef struct packed {
    logic osc_req;
    logic osc_running;
    logic qualifying;
  } cwgf_status_t;

  typedef enum logic [1:0] {
    st_idle,
    st_osc_start,
    st_qualify,
    st_wake
  } cwgf_state_t;

endpackage

// ---- src/cwgf_osc_tick.sv ----
`timescale 1ns/1ns
module cwgf_osc_tick
  import cwgf_pkg::*;
#(
  parameter int unsigned START_CYC = CWGF_OSC_START_CYC,
  parameter int unsigned DIV = CWGF_TICK_DIV
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic sys_rst_in,
  // power control
  input wire logic power_in,
  // oscillator view
  output logic running_out,
  output logic tick_out
);

  logic [7:0] start_q;
  logic [3:0] div_q;
  logic running_q;
  logic tick_q;

  // ****************************************
  // startup from powerdown
  // ****************************************
  always_ff @(posedge clock_in) begin
    if (sys_rst_in || !power_in) begin
      start_q <= 8'h00;
      running_q <= 1'b0;
    end else if (!running_q) begin
      if (start_q == 8'(START_CYC - 1)) begin
        running_q <= 1'b1;
      end else begin
        start_q <= start_q + 8'h01;
      end
    end
  end

  // ****************************************
  // oscillator tick divider
  // ****************************************
  always_ff @(posedge clock_in) begin
    if (sys_rst_in || !running_q) begin
      div_q <= 4'h0;
      tick_q <= 1'b0;
    end else if (div_q == 4'(DIV - 1)) begin
      div_q <= 4'h0;
      tick_q <= 1'b1;
    end else begin
      div_q <= div_q + 4'h1;
      tick_q <= 1'b0;
    end
  end

  assign running_out = running_q;
  assign tick_out = tick_q;

endmodule // cwgf_osc_tick

// ---- src/cwgf_filter.sv ----
// Behaviour
// - in stop or sleep, dominant pulses under 1.5 us raise no wakeup
// - in stop, outside low power states and standby, a dominant pulse of 5 us or more raises a wakeup
// - wake threshold lies between 1.5 us and 5 us
// - a qualified pulse asserts the CAN wakeup interrupt
// - powered down oscillator is restarted first, then qualification begins
// - oscillator already running: qualification starts at once
// - worst latency 4834.38 ns from powerdown, 4414.38 ns running
// - filtered wakeup is inactive in the very low power states
// - filtered wakeup is inactive in oscillator standby
// - threshold band holds for oscillator error of -3 to +5 percent
// - oscillator startup of 280 to 700 ns is allowed for
`timescale 1ns/1ns
module cwgf_filter
  import cwgf_pkg::*;
#(
  parameter int unsigned THRESH_TICKS = CWGF_THRESH_TICKS
) (
  // clock and reset
  input wire logic clock_in,
  input wire logic sys_rst_in,
  // bus receive pin, dominant low
  input wire logic can_rx_in,
  // operating modes
  input wire cwgf_mode_t mode_in,
  // interrupt acknowledge from controller
  input wire logic wake_ack_in,
  // interrupt and status
  output logic wake_irq_out,
  output cwgf_status_t status_out
);

  localparam int LAT_PD_CYC = CWGF_LAT_PD_CYC;
  localparam int LAT_RUN_CYC = CWGF_LAT_RUN_CYC;
  localparam int START_BOUND = CWGF_OSC_START_CYC + 1;
  localparam int QUAL_BOUND = THRESH_TICKS * CWGF_TICK_DIV + 2;

  logic rx_s1_q;
  logic rx_s2_q;
  logic rx_dom;
  logic enabled;
  logic osc_running;
  logic osc_tick;
  logic osc_req_q;
  logic osc_power;
  logic wake_irq_q;
  logic wake_set;
  logic [7:0] cnt_q;
  cwgf_state_t state_q;
  cwgf_status_t status_q;

  // ****************************************
  // pin synchroniser
  // ****************************************
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      rx_s1_q <= 1'b1;
      rx_s2_q <= 1'b1;
    end else begin
      rx_s1_q <= can_rx_in;
      rx_s2_q <= rx_s1_q;
    end
  end

  assign rx_dom = !rx_s2_q;
  // filter off outside stop, in low power states and in standby
  assign enabled = mode_in.ctrl_stop && !mode_in.very_low_power_states &&
                   !mode_in.osc_standby;
  assign osc_power = !mode_in.osc_powerdown || osc_req_q;

  // ****************************************
  // oscillator
  // ****************************************
  cwgf_osc_tick #(
    .START_CYC(CWGF_OSC_START_CYC),
    .DIV(CWGF_TICK_DIV)
  ) u_osc (
    .clock_in(clock_in),
    .sys_rst_in(sys_rst_in),
    .power_in(osc_power),
    .running_out(osc_running),
    .tick_out(osc_tick)
  );

  // ****************************************
  // qualification state machine
  // ****************************************
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      state_q <= st_idle;
    end else if (!enabled && state_q != st_wake) begin
      state_q <= st_idle;
    end else begin
      case (state_q)
        st_idle: begin
          if (rx_dom && osc_running) begin
            state_q <= st_qualify;
          end else if (rx_dom) begin
            state_q <= st_osc_start;
          end
        end
        st_osc_start: begin
          if (!rx_dom) begin
            state_q <= st_idle;
          end else if (osc_running) begin
            state_q <= st_qualify;
          end
        end
        st_qualify: begin
          if (!rx_dom) begin
            state_q <= st_idle;
          end else if (wake_set) begin
            state_q <= st_wake;
          end
        end
        st_wake: begin
          if (wake_ack_in) begin
            state_q <= st_idle;
          end
        end
        default: begin
          state_q <= st_idle;
        end
      endcase
    end
  end

  // ****************************************
  // dominant tick counter
  // ****************************************
  assign wake_set = (state_q == st_qualify) && rx_dom && osc_tick &&
                    (cnt_q == 8'(THRESH_TICKS - 1));

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      cnt_q <= 8'h00;
    end else if (state_q != st_qualify || !rx_dom) begin
      cnt_q <= 8'h00;
    end else if (osc_tick) begin
      cnt_q <= cnt_q + 8'h01;
    end
  end

  // ****************************************
  // oscillator restart request
  // ****************************************
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      osc_req_q <= 1'b0;
    end else if (state_q == st_idle && enabled && rx_dom && !osc_running) begin
      osc_req_q <= 1'b1;
    end else if (state_q == st_idle || state_q == st_wake) begin
      osc_req_q <= 1'b0;
    end
  end

  // ****************************************
  // wakeup interrupt, set wins over clear
  // ****************************************
  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      wake_irq_q <= 1'b0;
    end else if (wake_set) begin
      wake_irq_q <= 1'b1;
    end else if (wake_ack_in) begin
      wake_irq_q <= 1'b0;
    end
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in) begin
      status_q <= '0;
    end else begin
      status_q.osc_req <= osc_req_q;
      status_q.osc_running <= osc_running;
      status_q.qualifying <= (state_q == st_qualify);
    end
  end

  assign wake_irq_out = wake_irq_q;
  assign status_out = status_q;

  // ****************************************
  // checking helpers
  // ****************************************
  logic [9:0] dom_cyc_q;
  logic [9:0] en_dom_cyc_q;
  logic [9:0] run_dom_cyc_q;

  always_ff @(posedge clock_in) begin
    if (sys_rst_in || !rx_dom) begin
      dom_cyc_q <= 10'h000;
    end else if (dom_cyc_q != 10'h3FF) begin
      dom_cyc_q <= dom_cyc_q + 10'h001;
    end
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in || !rx_dom || !enabled || state_q == st_wake) begin
      en_dom_cyc_q <= 10'h000;
    end else if (en_dom_cyc_q != 10'h3FF) begin
      en_dom_cyc_q <= en_dom_cyc_q + 10'h001;
    end
  end

  always_ff @(posedge clock_in) begin
    if (sys_rst_in || !rx_dom || !enabled || !osc_running || state_q == st_wake) begin
      run_dom_cyc_q <= 10'h000;
    end else if (run_dom_cyc_q != 10'h3FF) begin
      run_dom_cyc_q <= run_dom_cyc_q + 10'h001;
    end
  end

  // ****************************************
  // assertions
  // ****************************************
  property p_no_short_wake;
    @(posedge clock_in) disable iff (sys_rst_in)
    wake_set |-> (dom_cyc_q >= 10'(CWGF_GLITCH_CYC));
  endproperty
  a_no_short_wake: assert property (p_no_short_wake)
    else $error("wakeup raised for a short pulse");

  property p_long_wakes;
    @(posedge clock_in) disable iff (sys_rst_in)
    (en_dom_cyc_q == 10'(LAT_PD_CYC)) |-> 1'b0;
  endproperty
  a_long_wakes: assert property (p_long_wakes)
    else $error("long pulse failed to wake in time");

  // wake time scaled by the oscillator error must stay inside the band
  property p_band;
    @(posedge clock_in) disable iff (sys_rst_in)
    wake_set |-> CWGF_BAND_OK &&
      (en_dom_cyc_q * CWGF_CLK_NS * 100 >= CWGF_GLITCH_MAX_NS * (100 + CWGF_ERR_POS_PCT)) &&
      (en_dom_cyc_q * CWGF_CLK_NS * 100 <= CWGF_WAKE_MIN_NS * (100 - CWGF_ERR_NEG_PCT));
  endproperty
  a_band: assert property (p_band)
    else $error("threshold outside wake band");

  property p_irq_cause;
    @(posedge clock_in) disable iff (sys_rst_in)
    $rose(wake_irq_q) |-> $past(state_q == st_qualify) && $past(osc_tick) &&
      ($past(cnt_q) == 8'(THRESH_TICKS - 1)) ##1 (state_q == st_wake || !enabled);
  endproperty
  a_irq_cause: assert property (p_irq_cause)
    else $error("interrupt without qualified pulse");

  property p_no_count_cold;
    @(posedge clock_in) disable iff (sys_rst_in)
    !osc_running |-> (cnt_q == 8'h00) && (state_q != st_qualify || !rx_dom ||
      $past(osc_running));
  endproperty
  a_no_count_cold: assert property (p_no_count_cold)
    else $error("qualification while oscillator stopped");

  property p_immediate;
    @(posedge clock_in) disable iff (sys_rst_in)
    (state_q == st_idle && enabled && rx_dom && osc_running) |=> state_q == st_qualify;
  endproperty
  a_immediate: assert property (p_immediate)
    else $error("qualification did not start at once");

  property p_run_latency;
    @(posedge clock_in) disable iff (sys_rst_in)
    (run_dom_cyc_q == 10'(LAT_RUN_CYC)) |-> 1'b0;
  endproperty
  a_run_latency: assert property (p_run_latency)
    else $error("running oscillator latency exceeded");

  property p_disabled;
    @(posedge clock_in) disable iff (sys_rst_in)
    (!enabled && state_q != st_wake) |=> (state_q == st_idle) && !wake_set;
  endproperty
  a_disabled: assert property (p_disabled)
    else $error("filter active while disabled");

  property p_startup;
    @(posedge clock_in) disable iff (sys_rst_in)
    $rose(osc_req_q) && !osc_running |->
      (!osc_running [*8]) ##[1:START_BOUND] (osc_running || !osc_req_q);
  endproperty
  a_startup: assert property (p_startup)
    else $error("oscillator startup outside budget");

  property p_clear_recessive;
    @(posedge clock_in) disable iff (sys_rst_in)
    (state_q == st_qualify && !rx_dom) |=> (cnt_q == 8'h00) && (state_q == st_idle);
  endproperty
  a_clear_recessive: assert property (p_clear_recessive)
    else $error("count not cleared on recessive");

  property p_qual_bound;
    @(posedge clock_in) disable iff (sys_rst_in)
    ($rose(state_q == st_qualify)) |-> ##[1:QUAL_BOUND]
      (wake_irq_q || !rx_dom || !enabled);
  endproperty
  a_qual_bound: assert property (p_qual_bound)
    else $error("qualification took too long");

  c_wake_run: cover property (@(posedge clock_in) disable iff (sys_rst_in)
    $rose(wake_irq_q) && !$past(osc_req_q));
  c_wake_pd: cover property (@(posedge clock_in) disable iff (sys_rst_in)
    $rose(wake_irq_q) && $past(osc_req_q));
  c_glitch: cover property (@(posedge clock_in) disable iff (sys_rst_in)
    state_q == st_qualify && !rx_dom && cnt_q != 8'h00);
  c_ack: cover property (@(posedge clock_in) disable iff (sys_rst_in)
    wake_irq_q && wake_ack_in);

endmodule // cwgf_filter

// ---- verif/cwgf_bus_model.sv ----
`timescale 1ns/1ns
module cwgf_bus_model (
  // clock
  input wire logic clock_in,
  // receive line as the transceiver shows it
  output logic can_rx_out
);
  // ****************************************
  // line idles recessive
  // ****************************************
  initial begin
    can_rx_out = 1'b1;
  end

  // ****************************************
  // dominant pulse of n cycles, edges at falling clock
  // ****************************************
  task automatic dominant(input int unsigned n);
    @(negedge clock_in);
    can_rx_out = 1'b0;
    repeat (n) @(negedge clock_in);
    can_rx_out = 1'b1;
  endtask
endmodule // cwgf_bus_model

// ---- verif/can_wakeup_glitch_filter_tb.sv ----
`timescale 1ns/1ns
`define CHK(what, exp, got) begin \
  checks_done++; \
  if ((got) !== (exp)) begin \
    n_fail++; \
    $display("[FAIL] %s exp %0h got %0h", what, exp, got); \
  end \
end
module can_wakeup_glitch_filter_tb;
  import cwgf_pkg::*;
  logic clock_in;
  logic sys_rst_in;
  logic can_rx;
  cwgf_mode_t mode_in;
  logic wake_ack_in;
  logic wake_irq_out;
  cwgf_status_t status_out;
  int n_fail;
  int checks_done;

  // ****************************************
  // clock, design and bus
  // ****************************************
  initial clock_in = 1'b0;
  always #20 clock_in = ~clock_in;

  cwgf_filter u_dut (
    .clock_in(clock_in),
    .sys_rst_in(sys_rst_in),
    .can_rx_in(can_rx),
    .mode_in(mode_in),
    .wake_ack_in(wake_ack_in),
    .wake_irq_out(wake_irq_out),
    .status_out(status_out)
  );

  cwgf_bus_model u_bus (
    .clock_in(clock_in),
    .can_rx_out(can_rx)
  );

  // ****************************************
  // shared tasks
  // ****************************************
  task automatic conclude();
    if (n_fail == 0 && checks_done > 0) begin
      $display("Test passed");
    end else begin
      $display("Test failed");
    end
    $finish;
  endtask

  task automatic set_mode(input logic [3:0] m);
    @(negedge clock_in);
    mode_in = m;
    repeat (4) @(negedge clock_in);
  endtask

  // cycles from falling pin to wake, plus status bits seen on the way
  task automatic watch(output int lat, output logic req_seen, output logic q_seen);
    lat = 0;
    req_seen = 1'b0;
    q_seen = 1'b0;
    @(negedge clock_in);
    while (lat < 200 && wake_irq_out !== 1'b1) begin
      @(negedge clock_in);
      lat++;
      req_seen |= status_out.osc_req;
      q_seen |= status_out.qualifying;
    end
  endtask

  task automatic run_pulse(input int unsigned n, output int lat, output logic req_seen,
                           output logic q_seen);
    fork
      u_bus.dominant(n);
      watch(lat, req_seen, q_seen);
    join
    repeat (4) @(negedge clock_in);
  endtask

  task automatic ack();
    @(negedge clock_in);
    wake_ack_in = 1'b1;
    @(negedge clock_in);
    wake_ack_in = 1'b0;
    `CHK("irq_after_ack", 1'b0, wake_irq_out)
  endtask

  // ****************************************
  // scenarios
  // ****************************************
  task automatic t_reset();
    `CHK("irq_reset", 1'b0, wake_irq_out)
    `CHK("status_reset", 3'h0, status_out)
  endtask

  task automatic t_glitch();
    int lat;
    logic rs;
    logic qs;
    set_mode(4'h8);
    run_pulse(CWGF_GLITCH_CYC - 1, lat, rs, qs);
    `CHK("irq_glitch", 1'b0, wake_irq_out)
    `CHK("glitch_qualified", 1'b1, qs)
    `CHK("glitch_no_restart", 1'b0, rs)
  endtask

  task automatic t_split();
    // three short pieces together exceed the threshold
    u_bus.dominant(CWGF_GLITCH_CYC - 2);
    u_bus.dominant(CWGF_GLITCH_CYC - 2);
    u_bus.dominant(CWGF_GLITCH_CYC - 2);
    repeat (20) @(negedge clock_in);
    `CHK("irq_split", 1'b0, wake_irq_out)
  endtask

  task automatic t_run_wake();
    int lat;
    logic rs;
    logic qs;
    int t_ns;
    set_mode(4'h8);
    run_pulse(125, lat, rs, qs);
    t_ns = lat * CWGF_CLK_NS;
    `CHK("irq_5us", 1'b1, wake_irq_out)
    `CHK("lat_run_max", 1'b1, lat <= CWGF_LAT_RUN_CYC)
    `CHK("lat_min", 1'b1, lat >= CWGF_GLITCH_CYC)
    `CHK("band_lo", 1'b1, t_ns * 100 >= CWGF_GLITCH_MAX_NS * (100 + CWGF_ERR_POS_PCT))
    `CHK("band_hi", 1'b1, t_ns * 100 <= CWGF_WAKE_MIN_NS * (100 - CWGF_ERR_NEG_PCT))
    `CHK("no_restart", 1'b0, rs)
    `CHK("osc_running_run", 1'b1, status_out.osc_running)
    `CHK("qualify_seen", 1'b1, qs)
    repeat (30) @(negedge clock_in);
    `CHK("irq_sticky", 1'b1, wake_irq_out)
    ack();
  endtask

  task automatic t_pd_wake();
    int lat;
    logic rs;
    logic qs;
    set_mode(4'h9);
    repeat (20) @(negedge clock_in);
    `CHK("osc_off_pd", 1'b0, status_out.osc_running)
    run_pulse(125, lat, rs, qs);
    `CHK("irq_pd", 1'b1, wake_irq_out)
    `CHK("restart_seen", 1'b1, rs)
    `CHK("lat_pd_max", 1'b1, lat <= CWGF_LAT_PD_CYC)
    `CHK("lat_pd_start", 1'b1, lat >= CWGF_GLITCH_CYC + CWGF_OSC_START_MIN_CYC)
    `CHK("osc_off_after_wake", 1'b0, status_out.osc_running)
    ack();
  endtask

  task automatic t_disabled();
    logic [3:0] modes [3];
    int lat;
    logic rs;
    logic qs;
    modes = '{4'hC, 4'hA, 4'h0};
    for (int i = 0; i < 3; i++) begin
      set_mode(modes[i]);
      run_pulse(130, lat, rs, qs);
      `CHK("irq_disabled", 1'b0, wake_irq_out)
      `CHK("qualify_disabled", 1'b0, qs)
    end
  endtask

  // ****************************************
  // main sequence and watchdog
  // ****************************************
  initial begin
    n_fail = 0;
    checks_done = 0;
    sys_rst_in = 1'b1;
    mode_in = 4'h0;
    wake_ack_in = 1'b0;
    repeat (12) @(negedge clock_in);
    sys_rst_in = 1'b0;
    t_reset();
    repeat (30) @(negedge clock_in);
    t_glitch();
    t_split();
    t_run_wake();
    t_pd_wake();
    t_disabled();
    t_run_wake();
    conclude();
  end

  initial begin
    repeat (20000) @(posedge clock_in);
    n_fail++;
    conclude();
  end
endmodule // can_wakeup_glitch_filter_tb
